// >>> src/tcpc_pkg.sv
// constants for the cell performance counter bank
`default_nettype none
package tcpc_pkg;
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 8;
	localparam int CNT_W       = 19;
	localparam int HOLD_W      = 11;
	localparam int NUM_CNT     = 7;
	localparam int IRQ_W       = 2;
	localparam int REF_PER_SEC = 8000;
	localparam int REF_CNT_W   = 13;

	localparam logic [7:0] OFS_IDLE_LO  = 8'h30;
	localparam logic [7:0] OFS_IDLE_MID = 8'h31;
	localparam logic [7:0] OFS_IDLE_HI  = 8'h32;
	localparam logic [7:0] OFS_CELL_DELINEATION_LOSS     = 8'h33;
	localparam logic [7:0] OFS_TX_LO    = 8'h34;
	localparam logic [7:0] OFS_TX_MID   = 8'h35;
	localparam logic [7:0] OFS_TX_HI    = 8'h36;
	localparam logic [7:0] OFS_CORR     = 8'h37;
	localparam logic [7:0] OFS_RX_LO    = 8'h38;
	localparam logic [7:0] OFS_RX_MID   = 8'h39;
	localparam logic [7:0] OFS_RX_HI    = 8'h3a;
	localparam logic [7:0] OFS_UNC      = 8'h3b;
	localparam logic [7:0] OFS_REJ_LO   = 8'h3c;
	localparam logic [7:0] OFS_REJ_HI   = 8'h3d;
	localparam logic [7:0] OFS_CTRL     = 8'h3e;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h3f;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h40;

	localparam logic [2:0] CI_IDLE = 3'h0;
	localparam logic [2:0] CI_CELL_DELINEATION_LOSS = 3'h1;
	localparam logic [2:0] CI_TX   = 3'h2;
	localparam logic [2:0] CI_CORR = 3'h3;
	localparam logic [2:0] CI_RX   = 3'h4;
	localparam logic [2:0] CI_UNC  = 3'h5;
	localparam logic [2:0] CI_REJ  = 3'h6;

	localparam logic [1:0] BYTE_LO  = 2'h0;
	localparam logic [1:0] BYTE_MID = 2'h1;
	localparam logic [1:0] BYTE_HI  = 2'h2;

	localparam int CTRL_LATCH = 0;
	localparam int IRQ_CELL_DELINEATION_LOSS   = 0;
	localparam int IRQ_SEC    = 1;
	localparam logic             CTRL_RST = 1'h0;
	localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

	function automatic logic [CNT_W-1:0] cnt_mask(input logic [2:0] idx);
		case (idx)
			CI_IDLE, CI_TX, CI_RX: cnt_mask = 19'h7ffff;
			CI_REJ:                cnt_mask = 19'h0ffff;
			default:               cnt_mask = 19'h000ff;
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> src/tcpc_counters.sv
// clear-on-read cell performance counter bank with one-second latching
// Contract
// - the idle cell count shows bits 18..16 in its high byte, cleared on read.
// - bits 7..3 of every three-byte high byte read as zero.
// - an 8-bit count rises once per loss of delineation, not on regain.
// - the delineation interrupt fires on both loss and regain.
// - sent cells are counted in 19 bits over three bytes, cleared on read.
// - corrected header errors are counted in 8 bits, cleared on read.
// - received cells are counted in 19 bits over three bytes, cleared on read.
// - uncorrected header errors are counted in 8 bits, cleared on read.
// - rejected cells are counted in 16 bits over two bytes, cleared on read.
// - with latching on, counts show the last full second and stay clear.
// - a one-second event follows 8000 periods of the 8 kHz reference.
`default_nettype none
module tcpc_counters
	import tcpc_pkg::*;
#(
	parameter int REF_PERIODS = tcpc_pkg::REF_PER_SEC
)(
	input  wire logic                        core_clk,
	input  wire logic                        nrst,
	input  wire logic                        ce,
	input  wire logic [tcpc_pkg::ADDR_W-1:0] addr,
	input  wire logic [tcpc_pkg::DATA_W-1:0] wrData,
	input  wire logic                        wrStb,
	input  wire logic                        rdStb,
	output var  logic [tcpc_pkg::DATA_W-1:0] rdData,
	input  wire logic                        idleCellEvt,
	input  wire logic                        cellDelineationLoss,
	input  wire logic                        sentCellEvt,
	input  wire logic                        fixedHecEvt,
	input  wire logic                        rxCellEvt,
	input  wire logic                        unfixedHecEvt,
	input  wire logic                        rejCellEvt,
	input  wire logic                        refClk8k,
	output var  logic                        oneSecondPulse,
	output var  logic                        irq
);
	import tcpc_pkg::*;

	localparam logic [REF_CNT_W-1:0] REF_LAST =
		REF_CNT_W'(REF_PERIODS - 1);

	// address decode: {hit, byte, counter index}
	function automatic logic [5:0] reg_sel(input logic [ADDR_W-1:0] a);
		case (a)
			OFS_IDLE_LO:  reg_sel = {1'b1, BYTE_LO, CI_IDLE};
			OFS_IDLE_MID: reg_sel = {1'b1, BYTE_MID, CI_IDLE};
			OFS_IDLE_HI:  reg_sel = {1'b1, BYTE_HI, CI_IDLE};
			OFS_CELL_DELINEATION_LOSS:     reg_sel = {1'b1, BYTE_LO, CI_CELL_DELINEATION_LOSS};
			OFS_TX_LO:    reg_sel = {1'b1, BYTE_LO, CI_TX};
			OFS_TX_MID:   reg_sel = {1'b1, BYTE_MID, CI_TX};
			OFS_TX_HI:    reg_sel = {1'b1, BYTE_HI, CI_TX};
			OFS_CORR:     reg_sel = {1'b1, BYTE_LO, CI_CORR};
			OFS_RX_LO:    reg_sel = {1'b1, BYTE_LO, CI_RX};
			OFS_RX_MID:   reg_sel = {1'b1, BYTE_MID, CI_RX};
			OFS_RX_HI:    reg_sel = {1'b1, BYTE_HI, CI_RX};
			OFS_UNC:      reg_sel = {1'b1, BYTE_LO, CI_UNC};
			OFS_REJ_LO:   reg_sel = {1'b1, BYTE_LO, CI_REJ};
			OFS_REJ_HI:   reg_sel = {1'b1, BYTE_HI, CI_REJ};
			default:      reg_sel = 6'h00;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] cnt_inc(
		input logic [CNT_W-1:0] v,
		input logic [2:0]       idx
	);
		cnt_inc = (v + 19'h00001) & cnt_mask(idx);
	endfunction

	logic                 refMeta;
	logic                 refSync;
	logic                 refPrev;
	logic [REF_CNT_W-1:0] refCnt;
	logic                 oneSec;
	logic                 locdPrev;
	logic                 latchEn;
	logic [IRQ_W-1:0]     irqStat;
	logic [IRQ_W-1:0]     irqMask;
	logic [CNT_W-1:0]     acc [NUM_CNT];
	logic [CNT_W-1:0]     shown [NUM_CNT];
	logic [HOLD_W-1:0]    hold [NUM_CNT];

	logic [REF_CNT_W-1:0] next_refCnt;
	logic                 next_oneSec;
	logic                 next_latchEn;
	logic [IRQ_W-1:0]     next_irqStat;
	logic [IRQ_W-1:0]     next_irqMask;
	logic                 next_irq;
	logic [CNT_W-1:0]     next_acc [NUM_CNT];
	logic [CNT_W-1:0]     next_shown [NUM_CNT];
	logic [HOLD_W-1:0]    next_hold [NUM_CNT];
	logic [DATA_W-1:0]    next_rdData;

	logic                 refEdge;
	logic                 locdRise;
	logic                 locdChg;
	logic                 loadSec;
	logic [NUM_CNT-1:0]   evt;
	logic [NUM_CNT-1:0]   clrHit;
	logic [5:0]           sel;
	logic                 selHit;
	logic [1:0]           selByte;
	logic [2:0]           selIdx;
	logic [CNT_W-1:0]     view [NUM_CNT];

	assign refEdge  = refSync & ~refPrev;
	assign locdRise = cellDelineationLoss & ~locdPrev;
	assign locdChg  = cellDelineationLoss ^ locdPrev;
	assign loadSec  = oneSec & latchEn;
	assign evt = {rejCellEvt, unfixedHecEvt, rxCellEvt, fixedHecEvt,
		sentCellEvt, locdRise, idleCellEvt};
	assign sel     = reg_sel(addr);
	assign selHit  = sel[5];
	assign selByte = sel[4:3];
	assign selIdx  = sel[2:0];

	// one-second timebase from the synchronised reference
	always_comb
	begin
		next_refCnt = refCnt;
		next_oneSec = 1'b0;
		if (refEdge)
		begin
			if (refCnt == REF_LAST)
			begin
				next_refCnt = '0;
				next_oneSec = 1'b1;
			end
			else
				next_refCnt = refCnt + 13'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			refMeta  <= 1'b0;
			refSync  <= 1'b0;
			refPrev  <= 1'b0;
			refCnt   <= '0;
			oneSec   <= 1'b0;
			locdPrev <= 1'b0;
		end
		else if (ce)
		begin
			refMeta  <= refClk8k;
			refSync  <= refMeta;
			refPrev  <= refSync;
			refCnt   <= next_refCnt;
			oneSec   <= next_oneSec;
			locdPrev <= cellDelineationLoss;
		end
	end

	// counters: live accumulators and the latched one-second snapshot
	always_comb
	begin
		for (int i = 0; i < NUM_CNT; i++)
		begin
			view[i] = latchEn ? shown[i] : acc[i];
			clrHit[i] = rdStb && selHit && selByte == BYTE_LO
				&& selIdx == 3'(i);
			next_acc[i]   = acc[i];
			next_shown[i] = shown[i];
			if (loadSec)
			begin
				next_shown[i] = acc[i];
				next_acc[i]   = evt[i] ? 19'h00001 : 19'h00000;
			end
			else
			begin
				if (clrHit[i] && !latchEn)
					next_acc[i] = evt[i] ? 19'h00001 : 19'h00000;
				else if (evt[i])
					next_acc[i] = cnt_inc(acc[i], 3'(i));
				if (clrHit[i] && latchEn)
					next_shown[i] = '0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < NUM_CNT; i++)
			begin
				acc[i]   <= '0;
				shown[i] <= '0;
			end
		end
		else if (ce)
		begin
			for (int i = 0; i < NUM_CNT; i++)
			begin
				acc[i]   <= next_acc[i];
				shown[i] <= next_shown[i];
			end
		end
	end

	// register read path with upper-byte capture
	always_comb
	begin
		next_rdData = 8'h00;
		for (int i = 0; i < NUM_CNT; i++)
			next_hold[i] = hold[i];
		if (rdStb && selHit)
		begin
			case (selByte)
				BYTE_LO:
				begin
					next_rdData = view[selIdx][7:0];
					next_hold[selIdx] = view[selIdx][18:8];
				end
				BYTE_MID:
					next_rdData = hold[selIdx][7:0];
				BYTE_HI:
					if (selIdx == CI_REJ)
						next_rdData = hold[selIdx][7:0];
					else
						next_rdData = {5'h00, hold[selIdx][10:8]};
				default:
					next_rdData = 8'h00;
			endcase
		end
		else if (rdStb && addr == OFS_CTRL)
			next_rdData = {7'h00, latchEn};
		else if (rdStb && addr == OFS_IRQ_STAT)
			next_rdData = {6'h00, irqStat};
		else if (rdStb && addr == OFS_IRQ_MASK)
			next_rdData = {6'h00, irqMask};
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdData <= 8'h00;
			for (int i = 0; i < NUM_CNT; i++)
				hold[i] <= '0;
		end
		else if (ce)
		begin
			rdData <= next_rdData;
			for (int i = 0; i < NUM_CNT; i++)
				hold[i] <= next_hold[i];
		end
	end

	// control, sticky interrupt status and mask
	always_comb
	begin
		logic [IRQ_W-1:0] setBits;
		logic [IRQ_W-1:0] clrBits;
		setBits = '0;
		clrBits = '0;
		setBits[IRQ_CELL_DELINEATION_LOSS] = locdChg;
		setBits[IRQ_SEC]  = oneSec;
		next_latchEn = latchEn;
		next_irqMask = irqMask;
		if (wrStb && addr == OFS_CTRL)
			next_latchEn = wrData[CTRL_LATCH];
		if (wrStb && addr == OFS_IRQ_MASK)
			next_irqMask = wrData[IRQ_W-1:0];
		if (wrStb && addr == OFS_IRQ_STAT)
			clrBits = wrData[IRQ_W-1:0];
		// set beats a clear in the same cycle
		next_irqStat = (irqStat & ~clrBits) | setBits;
		next_irq = |(next_irqStat & next_irqMask);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			latchEn        <= CTRL_RST;
			irqMask        <= MASK_RST;
			irqStat        <= '0;
			irq            <= 1'b0;
			oneSecondPulse <= 1'b0;
		end
		else if (ce)
		begin
			latchEn        <= next_latchEn;
			irqMask        <= next_irqMask;
			irqStat        <= next_irqStat;
			irq            <= next_irq;
			oneSecondPulse <= next_oneSec;
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst || !ce);

	sequence txLowRead;
		rdStb && addr == OFS_TX_LO && !latchEn && !loadSec;
	endsequence

	sequence thenTxHigh;
		ce && rdStb && addr == OFS_TX_HI;
	endsequence

	rsvd_high_zero_a: assert property (
		rdStb && (addr == OFS_TX_HI || addr == OFS_RX_HI
		|| addr == OFS_IDLE_HI) |=> rdData[7:3] == 5'h00)
		else $error("reserved high byte bits not zero");

	cell_delineation_loss_count_a: assert property (
		ce && locdRise && !clrHit[CI_CELL_DELINEATION_LOSS] && !loadSec
		|=> acc[CI_CELL_DELINEATION_LOSS][7:0] == $past(acc[CI_CELL_DELINEATION_LOSS][7:0]) + 8'h01)
		else $error("delineation loss not counted");

	cell_delineation_loss_regain_a: assert property (
		ce && !locdRise && !clrHit[CI_CELL_DELINEATION_LOSS] && !loadSec
		|=> acc[CI_CELL_DELINEATION_LOSS] == $past(acc[CI_CELL_DELINEATION_LOSS]))
		else $error("delineation count moved without loss");

	cell_delineation_loss_irq_a: assert property (
		ce && locdChg |=> irqStat[IRQ_CELL_DELINEATION_LOSS])
		else $error("delineation change did not flag");

	tx_clear_a: assert property (
		txLowRead and (sentCellEvt && ce) |=> acc[CI_TX] == 19'h00001)
		else $error("event in clearing cycle lost");

	tx_hold_a: assert property (
		txLowRead ##1 thenTxHigh
		|=> rdData[2:0] == $past(acc[CI_TX][18:16], 2))
		else $error("high byte not consistent with low");

	rej_wrap_a: assert property (
		ce && rejCellEvt && !clrHit[CI_REJ] && !loadSec
		|=> acc[CI_REJ] == {3'h0, $past(acc[CI_REJ][15:0]) + 16'h0001})
		else $error("rejected count not 16 bits");

	corr_count_a: assert property (
		ce && fixedHecEvt && !clrHit[CI_CORR] && !loadSec
		|=> acc[CI_CORR] == {11'h000, $past(acc[CI_CORR][7:0]) + 8'h01})
		else $error("corrected error count wrong");

	unc_count_a: assert property (
		ce && unfixedHecEvt && !clrHit[CI_UNC] && !loadSec
		|=> acc[CI_UNC] == {11'h000, $past(acc[CI_UNC][7:0]) + 8'h01})
		else $error("uncorrected error count wrong");

	rx_count_a: assert property (
		ce && rxCellEvt && !clrHit[CI_RX] && !loadSec
		|=> acc[CI_RX] == $past(acc[CI_RX]) + 19'h00001)
		else $error("received cell count wrong");

	idle_high_a: assert property (
		rdStb && addr == OFS_IDLE_HI
		|=> rdData == {5'h00, $past(hold[CI_IDLE][10:8])})
		else $error("idle high byte not from hold");

	latch_clear_a: assert property (
		ce && latchEn && clrHit[CI_TX] && !loadSec
		|=> shown[CI_TX] == 19'h00000)
		else $error("latched count not cleared by read");

	latch_load_a: assert property (
		ce && loadSec |=> shown[CI_RX] == $past(acc[CI_RX]))
		else $error("one-second snapshot not taken");

	sec_pulse_a: assert property (
		ce && refEdge && refCnt == REF_LAST
		|=> oneSec && oneSecondPulse && refCnt == '0)
		else $error("one-second event missing");

	irq_level_a: assert property (
		irq == |(irqStat & irqMask))
		else $error("interrupt level does not follow status");
endmodule
`default_nettype wire

// >>> verif/tcpc_counters_tb.sv
// self-checking bench for the cell performance counter bank
`default_nettype none
module tcpc_counters_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tcpc_pkg::*;

	logic       core_clk = 1'b0;
	logic       nrst     = 1'b0;
	logic       ce       = 1'b1;
	logic       wrStb    = 1'b0;
	logic       rdStb    = 1'b0;
	logic       refClk8k = 1'b0;
	logic       lossLvl  = 1'b0;
	logic       rdSeen   = 1'b0;
	logic       refRun   = 1'b0;
	logic [7:0] addr     = 8'h00;
	logic [7:0] wrData   = 8'h00;
	logic [6:0] evt      = 7'h00;
	logic [7:0] rdData;
	logic       oneSecondPulse;
	logic       irq;
	logic [7:0] expQ[$];
	logic [7:0] adrQ[$];
	logic       irqQ[$];
	int         mismatches = 0;
	int         compares   = 0;
	int         seed       = 32'hc78d0fc2;
	int         secCnt     = 0;
	int         cycCnt     = 0;
	int         lastSec    = 0;
	int         period     = 0;
	int         refDiv     = 0;
	int         n;
	int         k;
	logic [2:0] idxT[6] = '{CI_IDLE, CI_TX, CI_RX, CI_REJ, CI_CORR, CI_UNC};
	logic [7:0] adrT[6] = '{OFS_IDLE_LO, OFS_TX_LO, OFS_RX_LO, OFS_REJ_LO,
		OFS_CORR, OFS_UNC};
	int         nbT[6]  = '{3, 3, 3, 2, 1, 1};

	tcpc_counters #(.REF_PERIODS(4)) u_dut (
		.core_clk(core_clk), .nrst(nrst), .ce(ce), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.idleCellEvt(evt[0]), .cellDelineationLoss(lossLvl),
		.sentCellEvt(evt[2]), .fixedHecEvt(evt[3]), .rxCellEvt(evt[4]),
		.unfixedHecEvt(evt[5]), .rejCellEvt(evt[6]), .refClk8k(refClk8k),
		.oneSecondPulse(oneSecondPulse), .irq(irq)
	);

	always #10 core_clk = ~core_clk;

	// reference runs fast in sim: 20 core cycles per period
	always @(posedge core_clk)
	begin
		rdSeen <= rdStb & ce;
		if (refRun)
		begin
			refDiv <= (refDiv == 9) ? 0 : refDiv + 1;
			if (refDiv == 9)
				refClk8k <= ~refClk8k;
		end
	end

	always @(negedge core_clk)
	begin
		cycCnt++;
		if (oneSecondPulse === 1'b1)
		begin
			period = cycCnt - lastSec;
			lastSec = cycCnt;
			secCnt++;
		end
		if (rdSeen === 1'b1 && expQ.size() > 0)
			chk8(adrQ.pop_front(), expQ.pop_front(), rdData);
		if (irqQ.size() > 0)
			chkBit(irqQ.pop_front(), irq);
	end

	task automatic chk8(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] s);
		compares++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error reg %h expected %h seen %h", a, e, s);
		end
	endtask

	task automatic chkBit(input logic e, input logic s);
		compares++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error irq expected %b seen %b", e, s);
		end
	endtask

	task automatic chkInt(input int e, input int s);
		compares++;
		if (s != e)
		begin
			mismatches++;
			$display("Error period expected %0d seen %0d", e, s);
		end
	endtask

	task automatic cyc(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] d, input logic [6:0] ev);
		wrStb <= w;
		rdStb <= r;
		addr <= a;
		wrData <= d;
		evt <= ev;
		@(posedge core_clk);
	endtask

	task automatic rdx(input logic [7:0] a, input logic [7:0] e,
		input logic [6:0] ev);
		expQ.push_back(e);
		adrQ.push_back(a);
		cyc(1'b0, 1'b1, a, 8'h00, ev);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rdx(a, e, 7'h00);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1'b1, 1'b0, a, d, 7'h00);
	endtask

	task automatic idle(input int c);
		repeat (c) cyc(1'b0, 1'b0, 8'h00, 8'h00, 7'h00);
	endtask

	task automatic pulse(input logic [2:0] idx, input int c);
		repeat (c) cyc(1'b0, 1'b0, 8'h00, 8'h00, 7'h01 << idx);
	endtask

	task automatic loss(input logic v);
		lossLvl <= v;
		idle(1);
	endtask

	task automatic irqExp(input logic v);
		irqQ.push_back(v);
		idle(1);
	endtask

	task automatic waitSec;
		int s;
		s = secCnt;
		for (int i = 0; i < 500 && secCnt == s; i++)
			idle(1);
		if (secCnt == s)
		begin
			mismatches++;
			$display("Error one-second pulse missing");
		end
	endtask

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		report_and_stop;
	end

	initial
	begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		for (int a = 'h30; a <= 'h40; a++)
			rd(8'(a), 8'h00);
		wr(OFS_TX_LO, 8'hff);
		wr(8'h7f, 8'hff);
		rd(OFS_TX_LO, 8'h00);
		rd(8'h7f, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			n = 1 + ($random(seed) & 'h1ff);
			pulse(idxT[i], n);
			rd(adrT[i], n[7:0]);
			if (nbT[i] > 1)
				rd(adrT[i] + 8'h01, n[15:8]);
			if (nbT[i] > 2)
				rd(adrT[i] + 8'h02, {5'h00, n[18:16]});
			rd(adrT[i], 8'h00);
		end
		pulse(CI_TX, 300);
		rd(OFS_TX_LO, 8'h2c);
		pulse(CI_TX, 512);
		rd(OFS_TX_MID, 8'h01);
		rd(OFS_TX_LO, 8'h00);
		rd(OFS_TX_HI, 8'h00);
		rd(OFS_TX_MID, 8'h02);
		pulse(CI_TX, 5);
		rdx(OFS_TX_LO, 8'h05, 7'h04);
		rd(OFS_TX_LO, 8'h01);
		// frozen clock enable hides events
		ce <= 1'b0;
		pulse(CI_TX, 3);
		ce <= 1'b1;
		rd(OFS_TX_LO, 8'h00);
		wr(OFS_IRQ_STAT, 8'h03);
		loss(1'b1);
		idle(2);
		irqExp(1'b0);
		rd(OFS_IRQ_STAT, 8'h01);
		wr(OFS_IRQ_STAT, 8'h01);
		rd(OFS_IRQ_STAT, 8'h00);
		loss(1'b0);
		idle(2);
		rd(OFS_IRQ_STAT, 8'h01);
		wr(OFS_IRQ_MASK, 8'h01);
		idle(2);
		irqExp(1'b1);
		wr(OFS_IRQ_STAT, 8'h01);
		idle(2);
		irqExp(1'b0);
		loss(1'b1);
		loss(1'b0);
		idle(1);
		rd(OFS_CELL_DELINEATION_LOSS, 8'h02);
		wr(OFS_CTRL, 8'h01);
		rd(OFS_CTRL, 8'h01);
		refRun <= 1'b1;
		waitSec;
		waitSec;
		chkInt(80, period);
		k = 1 + ($random(seed) & 'hf);
		pulse(CI_TX, k);
		waitSec;
		rd(OFS_TX_LO, 8'(k));
		pulse(CI_TX, 3);
		rd(OFS_TX_LO, 8'h00);
		waitSec;
		rd(OFS_TX_LO, 8'h03);
		refRun <= 1'b0;
		wr(OFS_CTRL, 8'h00);
		idle(2);
		report_and_stop;
	end
endmodule
`default_nettype wire
